// *** design/osm_pkg.sv ***
// package: operation codes, widths and reset values for the or/shift/move datapath
package osm_pkg;
    localparam int DATA_W = 8;
    localparam int IDX_W = 7;
    localparam int REG_COUNT = 128;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic ZERO_FLAG_RST = 1'b0;
    localparam logic SHIFT_OUT_RST = 1'b0;
    // operation select codes
    typedef enum logic [2:0] {
        OSM_OP_NONE = 3'h0,
        OSM_OP_OR_LIT = 3'h1,
        OSM_OP_OR_REG = 3'h2,
        OSM_OP_SHL = 3'h3,
        OSM_OP_SHR = 3'h4,
        OSM_OP_COPY = 3'h5
    } osm_op_t;
    localparam logic TARGET_ACC = 1'b0;
    localparam logic TARGET_REG = 1'b1;
endpackage : osm_pkg

// *** design/osm_alu.sv ***
// module: single-cycle or/shift/move execution datapath with its own data register file
`timescale 1ns/1ps
// What this block does
// - or-literal ors accumulator with 8-bit immediate, writes accumulator, updates zero flag
// - or-register ors accumulator with indexed register, updates zero flag, routes by target
// - target 0 writes result to accumulator, register untouched
// - target 1 writes result back into the indexed register, except or-literal, which always writes the accumulator
// - shift left: bit 7 to shift-out, bits 6..0 to 7..1, bit 0 zero
// - shift right: bit 7 zero, bits 7..1 to 6..0, bit 0 to shift-out
// - both shifts update shift-out and zero flag, result routed by target
// - copy passes register unchanged to target and updates zero flag
// - copy takes one instruction word and completes in one cycle
module osm_alu #(
    parameter int DATA_W = osm_pkg::DATA_W, // datapath width; the shift wiring serves only 8
    parameter int IDX_W = osm_pkg::IDX_W // register index width; the file serves only 7
) (
    input wire logic ref_clk, // core instruction clock
    input wire logic nrst, // asynchronous reset, active low
    input wire logic op_valid, // one-cycle strobe: execute op this cycle
    input wire osm_pkg::osm_op_t op_sel, // operation to execute
    input wire logic [7:0] immediate_literal, // literal operand for or-literal
    input wire logic [6:0] register_operand_index, // data register address
    input wire logic result_target_select, // 0 accumulator, 1 addressed register
    output logic [7:0] accumulator, // accumulator value
    output logic null_result_flag, // zero status flag
    output logic shift_out_bit, // bit shifted out by last shift
    output logic done, // pulse: op retired last edge
    output logic [7:0] reg_read_data // registered view of addressed register
);
    logic [7:0] acc_r;
    logic zero_r;
    logic shout_r;
    logic done_r;
    logic [7:0] rd_r;
    logic [7:0] regfile [osm_pkg::REG_COUNT];
    logic [7:0] opnd;
    logic [7:0] result;
    logic shout_nxt;
    logic writes_result;
    logic is_shift;
    logic [7:0] acc_nxt;

    // port widths, shift wiring and file depth are fixed, so refuse any other sizing at elaboration
    // rather than silently truncating operands or aliasing register addresses
    if (DATA_W != 8 || IDX_W != 7 || (2 ** IDX_W) != osm_pkg::REG_COUNT) begin : g_size_check
        $error("osm_alu serves only 8-bit data with a 7-bit register index");
    end

    // destination decode shared by the accumulator and register-file writers;
    // the literal op has no register operand, so it can never target the file
    function automatic logic goes_to_reg(input osm_pkg::osm_op_t sel, input logic tgt);
        return (sel != osm_pkg::OSM_OP_OR_LIT) && (tgt == osm_pkg::TARGET_REG);
    endfunction : goes_to_reg

    // zero test shared by every op that touches the zero flag
    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : is_zero

    assign opnd = regfile[register_operand_index];

    // result and shift-out selection, purely combinational so each op retires in one cycle
    always_comb begin
        result = opnd;
        shout_nxt = shout_r;
        writes_result = op_valid;
        is_shift = 1'b0;
        case (op_sel)
            osm_pkg::OSM_OP_OR_LIT: result = acc_r | immediate_literal;
            osm_pkg::OSM_OP_OR_REG: result = acc_r | opnd;
            osm_pkg::OSM_OP_SHL: begin
                result = {opnd[6:0], 1'b0};
                shout_nxt = opnd[7];
                is_shift = 1'b1;
            end
            osm_pkg::OSM_OP_SHR: begin
                result = {1'b0, opnd[7:1]};
                shout_nxt = opnd[0];
                is_shift = 1'b1;
            end
            osm_pkg::OSM_OP_COPY: result = opnd;
            default: writes_result = 1'b0;
        endcase
    end

    // or-literal always lands in the accumulator regardless of target select
    always_comb begin
        acc_nxt = acc_r;
        if (writes_result && (op_sel == osm_pkg::OSM_OP_OR_LIT)) begin
            acc_nxt = result;
        end else if (writes_result && !goes_to_reg(op_sel, result_target_select)) begin
            acc_nxt = result;
        end
    end

    // accumulator
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc_r <= osm_pkg::ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // register file write-back; the literal op never touches it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < osm_pkg::REG_COUNT; i++) begin
                regfile[i] <= osm_pkg::REG_RST;
            end
        end else if (writes_result && goes_to_reg(op_sel, result_target_select)) begin
            regfile[register_operand_index] <= result;
        end
    end

    // zero flag: every accepted op affects it; codes 0, 6 and 7 leave it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            zero_r <= osm_pkg::ZERO_FLAG_RST;
        end else if (writes_result) begin
            zero_r <= is_zero(result);
        end
    end

    // shift-out flag only moves on shifts; or and copy leave it alone
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shout_r <= osm_pkg::SHIFT_OUT_RST;
        end else if (writes_result && is_shift) begin
            shout_r <= shout_nxt;
        end
    end

    // retire pulse: every accepted op finishes at the edge that takes it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= writes_result;
        end
    end

    // read-back view shows the pre-write value, so a write-back is seen one edge later
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_r <= osm_pkg::REG_RST;
        end else begin
            rd_r <= opnd;
        end
    end

    assign accumulator = acc_r;
    assign null_result_flag = zero_r;
    assign shift_out_bit = shout_r;
    assign done = done_r;
    assign reg_read_data = rd_r;
endmodule : osm_alu

// *** sim/osm_alu_asserts.sv ***
// checker: port relations of the or/shift/move datapath
`timescale 1ns/1ps
module osm_alu_asserts (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire osm_pkg::osm_op_t op_sel,
    input wire logic [7:0] immediate_literal,
    input wire logic [6:0] register_operand_index,
    input wire logic result_target_select,
    input wire logic [7:0] accumulator,
    input wire logic null_result_flag,
    input wire logic shift_out_bit,
    input wire logic done,
    input wire logic [7:0] reg_read_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // codes 0, 6 and 7 are no-ops, so they are not a take
    wire [2:0] s = op_sel;
    wire take = op_valid && s inside {[3'h1:3'h5]};
    wire to_acc = take && !result_target_select;
    done_pulse_a: assert property (take |=> done) else $error("no done");
    no_op_a: assert property (!take |=> !done && $stable(accumulator)) else $error("no-op acted");
    or_lit_a: assert property (take && s == 3'h1 |=> accumulator == $past(accumulator | immediate_literal))
        else $error("or literal");
    or_reg_a: assert property (to_acc && s == 3'h2 |=> &(accumulator | ~$past(accumulator)))
        else $error("or register");
    reg_dest_a: assert property (take && s != 3'h1 && result_target_select |=> $stable(accumulator))
        else $error("acc written");
    shl_lsb_a: assert property (to_acc && s == 3'h3 |=> !accumulator[0]) else $error("shl lsb");
    shr_msb_a: assert property (to_acc && s == 3'h4 |=> !accumulator[7]) else $error("shr msb");
    zero_flag_a: assert property (take && (s == 3'h1 || !result_target_select) |=>
        null_result_flag == (accumulator == 8'h00)) else $error("zero flag");
    shout_keep_a: assert property (take && (s == 3'h1 || s == 3'h2 || s == 3'h5) |=> $stable(shift_out_bit))
        else $error("shift-out moved");
    cover property (to_acc && s == 3'h3);
    cover property (take && s == 3'h4 && result_target_select);
    cover property (take && s == 3'h5 && result_target_select);
    cover property (op_valid && s == 3'h6);
endmodule : osm_alu_asserts
bind osm_alu osm_alu_asserts chk_u (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_sel(op_sel),
    .immediate_literal(immediate_literal), .register_operand_index(register_operand_index),
    .result_target_select(result_target_select), .accumulator(accumulator), .null_result_flag(null_result_flag),
    .shift_out_bit(shift_out_bit), .done(done), .reg_read_data(reg_read_data));

// *** sim/or_shift_move_alu_ops_tb.sv ***
// testbench: directed runs of the or/shift/move datapath
`timescale 1ns/1ps
module or_shift_move_alu_ops_tb;
    logic ref_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, result_target_select = 1'b0;
    osm_pkg::osm_op_t op_sel = osm_pkg::OSM_OP_NONE;
    logic [7:0] immediate_literal = 8'h00, accumulator, reg_read_data;
    logic [6:0] register_operand_index = 7'h00;
    logic null_result_flag, shift_out_bit, done;
    int n_mismatch = 0, n_checks = 0;
    osm_alu dut_u (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_sel(op_sel),
        .immediate_literal(immediate_literal), .register_operand_index(register_operand_index),
        .result_target_select(result_target_select), .accumulator(accumulator), .null_result_flag(null_result_flag),
        .shift_out_bit(shift_out_bit), .done(done), .reg_read_data(reg_read_data));
    always #2 ref_clk = ~ref_clk;
    task chk(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one op strobe; f holds expected {zero, shift-out, done}
    task op(input logic [2:0] s, input logic [7:0] l, input logic [6:0] i, input logic t, input logic [7:0] a, f);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_sel <= osm_pkg::osm_op_t'(s);
        immediate_literal <= l;
        register_operand_index <= i;
        result_target_select <= t;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
        chk("acc", accumulator, a);
        chk("flags", {5'h0, null_result_flag, shift_out_bit, done}, f);
    endtask : op
    // the register view lags the index by one edge
    task rd(input logic [6:0] i, input logic [7:0] e);
        @(posedge ref_clk);
        register_operand_index <= i;
        @(posedge ref_clk);
        #1;
        chk("reg", reg_read_data, e);
    endtask : rd
    task t_or;
        op(3'h1, 8'h00, 7'h00, 1'b0, 8'h00, 8'h05);
        op(3'h1, 8'h81, 7'h00, 1'b1, 8'h81, 8'h01);
        op(3'h2, 8'h00, 7'h7f, 1'b0, 8'h81, 8'h01);
        rd(7'h7f, 8'h00);
        op(3'h2, 8'h00, 7'h7f, 1'b1, 8'h81, 8'h01);
        rd(7'h7f, 8'h81);
        $display("or test done");
    endtask : t_or
    task t_shift;
        op(3'h3, 8'h00, 7'h7f, 1'b1, 8'h81, 8'h03);
        rd(7'h7f, 8'h02);
        op(3'h4, 8'h00, 7'h7f, 1'b1, 8'h81, 8'h01);
        op(3'h4, 8'h00, 7'h7f, 1'b1, 8'h81, 8'h07);
        $display("shift test done");
    endtask : t_shift
    task t_copy;
        op(3'h5, 8'h00, 7'h7f, 1'b0, 8'h00, 8'h07);
        op(3'h1, 8'h40, 7'h00, 1'b0, 8'h40, 8'h03);
        op(3'h2, 8'h00, 7'h03, 1'b1, 8'h40, 8'h03);
        op(3'h3, 8'h00, 7'h03, 1'b0, 8'h80, 8'h01);
        op(3'h5, 8'h00, 7'h03, 1'b0, 8'h40, 8'h01);
        op(3'h5, 8'h00, 7'h7f, 1'b1, 8'h40, 8'h05);
        op(3'h6, 8'hff, 7'h03, 1'b0, 8'h40, 8'h04);
        op(3'h7, 8'hff, 7'h03, 1'b1, 8'h40, 8'h04);
        op(3'h0, 8'hff, 7'h03, 1'b1, 8'h40, 8'h04);
        rd(7'h03, 8'h40);
        $display("copy test done");
    endtask : t_copy
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // watchdog: a run this long has hung
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        t_or;
        t_shift;
        t_copy;
        close_out;
    end
endmodule : or_shift_move_alu_ops_tb
